// ---- design/cps_pkg.sv ----
// Constants, types and register map of the program-counter and status block
// Function
// RULE1: Flag bits set on their event regardless of any enable or global enable.
// RULE2: Software clears a pending flag before enabling its interrupt.
// RULE3: Low-voltage flag bit 7 set on low supply; only software zero clears it.
// RULE4: Bus-collision flag bit 3 set on master collision; only software clears it.
// RULE5: Unimplemented bits of flag and power-control registers read zero.
// RULE6: Speed bit 3 resets to one; internal RC: one fast, zero slow.
// RULE7: Resistor mode: one resistor-set, zero slow; other modes ignore the bit.
// RULE8: Power-on reset clears power-on bit 1; software sets it again.
// RULE9: Brown-out reset clears brown-out bit 0; software sets it again.
// RULE10: Brown-out bit undefined after power-on; meaningless with detector disabled.
// RULE11: 13-bit counter; low byte accessible, upper bits only via the latch.
// RULE12: Up to 8K words in pages reached by an 11-bit branch target.
// RULE13: Call or jump takes top two bits from latch bits 4:3.
// RULE14: Eight 13-bit return entries, pointer invisible to software.
// RULE15: Push on call or interrupt branch; pop on any return.
// RULE16: Push and pop leave the high latch untouched.
// RULE17: Stack wraps circularly; ninth push overwrites the first, silently.
// RULE18: Indirect location reaches the register the pointer addresses.
// RULE19: Indirect read of itself, pointer zero, returns zero.
// RULE20: Indirect write of itself stores nothing.
// RULE21: Effective address is bank bit 7 of status above pointer.
// RULE22: Writing the low byte loads upper bits from latch bits 4:0.
package cps_pkg;

  // ==========================================================
  // Bus and register map
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_PC_LOW = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_POINTER = 8'h04;
  localparam logic [7:0] IDX_LATCH = 8'h0a;
  localparam logic [7:0] IDX_FLAGS_TWO = 8'h0d;
  localparam logic [7:0] IDX_PC_VIEW = 8'h40;
  localparam logic [7:0] IDX_POWER = 8'h8e;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // Field positions, masks and reset values
  localparam int LOW_VOLT_BIT = 7;
  localparam int BUS_COLL_BIT = 3;
  localparam int OSC_SPEED_BIT = 3;
  localparam int POWER_ON_BIT = 1;
  localparam int BROWNOUT_BIT = 0;
  localparam int BANK_BIT = 7;
  localparam int PAGE_HI_BIT = 4;
  localparam int PAGE_LO_BIT = 3;
  localparam logic [7:0] LATCH_MASK = 8'h1f;
  localparam logic [7:0] FLAGS_TWO_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic OSC_SPEED_RST = 1'b1;

  // ==========================================================
  // Program counter, stack and file addressing
  localparam int PC_W = 13;
  localparam int TGT_W = 11;
  localparam int FILE_W = 9;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam logic [6:0] FILE_INDIRECT = 7'h00;
  localparam logic [6:0] FILE_PC_LOW = 7'h02;
  localparam logic [6:0] FILE_STATUS = 7'h03;
  localparam logic [6:0] FILE_POINTER = 7'h04;
  localparam logic [6:0] FILE_LATCH = 7'h0a;
  localparam logic [12:0] PC_RST = 13'h0000;

  typedef enum logic [1:0] {
    CPS_OSC_INTERNAL_RC,
    CPS_OSC_RESISTOR,
    CPS_OSC_OTHER
  } cps_osc_mode_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } cps_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cps_axi_rsp_t;

  typedef struct packed {
    logic step;
    logic jump;
    logic call;
    logic irq_branch;
    logic ret;
    logic [TGT_W-1:0] target;
    logic fr_valid;
    logic fr_we;
    logic [FILE_W-1:0] fr_addr;
    logic [7:0] fr_wdata;
  } cps_core_req_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic fa_valid;
    logic fa_we;
    logic fa_null;
    logic [FILE_W-1:0] fa_addr;
    logic [7:0] fa_wdata;
  } cps_core_rsp_t;

endpackage : cps_pkg

// ---- design/cps_core_pc_stack_status.sv ----
// Program counter, return stack, indirect addressing and status registers
`timescale 1ns/1ps
module cps_core_pc_stack_status #(
  parameter logic [12:0] IRQ_VECTOR = 13'h0004
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire cps_pkg::cps_axi_req_t axi_req,
  output cps_pkg::cps_axi_rsp_t axi_rsp,
  input wire cps_pkg::cps_core_req_t core_req,
  output cps_pkg::cps_core_rsp_t core_rsp,
  input wire logic low_voltage_event,
  input wire logic bus_collision_event,
  input wire logic power_on_cause,
  input wire logic brownout_cause,
  input wire cps_pkg::cps_osc_mode_t osc_mode,
  output logic osc_slow_select
);

  // ==========================================================
  // State
  cps_pkg::cps_axi_rsp_t rsp;
  cps_pkg::cps_axi_rsp_t next_rsp;
  logic aw_held;
  logic next_aw_held;
  logic w_held;
  logic next_w_held;
  logic [cps_pkg::ADDR_W-1:0] aw_addr;
  logic [cps_pkg::ADDR_W-1:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic w_lane0;
  logic next_w_lane0;

  logic [cps_pkg::PC_W-1:0] pc;
  logic [cps_pkg::PC_W-1:0] next_pc;
  logic [7:0] latch;
  logic [7:0] next_latch;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] pointer;
  logic [7:0] next_pointer;
  logic low_voltage_flag;
  logic next_low_voltage_flag;
  logic bus_collision_flag;
  logic next_bus_collision_flag;
  logic osc_speed_select;
  logic next_osc_speed_select;
  logic power_on_status;
  logic next_power_on_status;
  logic brownout_status;
  logic next_brownout_status;

  logic [cps_pkg::PC_W-1:0] stack_mem [cps_pkg::STACK_DEPTH];
  logic [cps_pkg::SP_W-1:0] sp;
  logic [cps_pkg::SP_W-1:0] next_sp;
  logic push_en;
  logic [cps_pkg::PC_W-1:0] push_data;

  cps_pkg::cps_core_rsp_t crsp;
  cps_pkg::cps_core_rsp_t next_crsp;
  logic osc_slow;
  logic next_osc_slow;

  // Write decode shared by bus and core
  logic bus_wr;
  logic [7:0] bus_wr_idx;
  logic bus_wr_hit;
  logic [7:0] bus_byte;
  logic core_wr;
  logic [6:0] core_wr_file;
  logic [7:0] pc_low_data;
  logic pc_low_wr;

  logic [7:0] rd_idx;
  logic [31:0] rd_word;
  logic rd_hit;
  localparam int ADDR_TOP = cps_pkg::ADDR_W - 1;

  // ==========================================================
  // Register read mux, unimplemented bits zero
  always_comb
  begin
    rd_idx = axi_req.araddr[9:2];
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_idx)
      cps_pkg::IDX_PC_LOW: rd_word[7:0] = pc[7:0];
      cps_pkg::IDX_STATUS: rd_word[7:0] = status;
      cps_pkg::IDX_POINTER: rd_word[7:0] = pointer;
      cps_pkg::IDX_LATCH: rd_word[7:0] = latch;
      cps_pkg::IDX_PC_VIEW: rd_word[cps_pkg::PC_W-1:0] = pc;
      cps_pkg::IDX_FLAGS_TWO:
      begin
        rd_word[cps_pkg::LOW_VOLT_BIT] = low_voltage_flag; // [RULE5]
        rd_word[cps_pkg::BUS_COLL_BIT] = bus_collision_flag; // [RULE5]
      end
      cps_pkg::IDX_POWER:
      begin
        rd_word[cps_pkg::OSC_SPEED_BIT] = osc_speed_select; // [RULE5]
        rd_word[cps_pkg::POWER_ON_BIT] = power_on_status;
        rd_word[cps_pkg::BROWNOUT_BIT] = brownout_status; // [RULE10]
      end
      default: rd_hit = 1'b0;
    endcase
    if (axi_req.araddr[ADDR_TOP:10] != '0)
    begin
      rd_hit = 1'b0;
      rd_word = 32'h0000_0000;
    end
  end

  // ==========================================================
  // Bus slave channel handling
  always_comb
  begin
    next_rsp = rsp;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    bus_wr = 1'b0;
    // Address and data taken in either order
    if (axi_req.awvalid && rsp.awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && rsp.wready)
    begin
      next_w_held = 1'b1;
      next_w_data = axi_req.wdata;
      next_w_lane0 = axi_req.wstrb[0];
    end
    // Both halves present: commit and answer
    if (aw_held && w_held && !rsp.bvalid)
    begin
      bus_wr = w_lane0;
      next_rsp.bvalid = 1'b1;
      next_rsp.bresp = bus_wr_hit ? cps_pkg::RESP_OKAY
                                  : cps_pkg::RESP_SLVERR;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
    end
    if (rsp.bvalid && axi_req.bready)
    begin
      next_rsp.bvalid = 1'b0;
    end
    next_rsp.awready = !next_aw_held && !next_rsp.bvalid;
    next_rsp.wready = !next_w_held && !next_rsp.bvalid;
    // Read: one outstanding, data registered
    if (axi_req.arvalid && rsp.arready)
    begin
      next_rsp.rvalid = 1'b1;
      next_rsp.rdata = rd_word;
      next_rsp.rresp = rd_hit ? cps_pkg::RESP_OKAY : cps_pkg::RESP_SLVERR;
    end
    else if (rsp.rvalid && axi_req.rready)
    begin
      next_rsp.rvalid = 1'b0;
    end
    next_rsp.arready = !next_rsp.rvalid;
  end

  // Write target decode
  always_comb
  begin
    bus_wr_idx = aw_addr[9:2];
    bus_byte = w_data[7:0];
    bus_wr_hit = (aw_addr[ADDR_TOP:10] == '0) &&
                 (bus_wr_idx == cps_pkg::IDX_PC_LOW ||
                  bus_wr_idx == cps_pkg::IDX_STATUS ||
                  bus_wr_idx == cps_pkg::IDX_POINTER ||
                  bus_wr_idx == cps_pkg::IDX_LATCH ||
                  bus_wr_idx == cps_pkg::IDX_FLAGS_TWO ||
                  bus_wr_idx == cps_pkg::IDX_POWER);
    core_wr = core_req.fr_valid && core_req.fr_we;
    core_wr_file = core_req.fr_addr[6:0];
    pc_low_wr = 1'b0;
    pc_low_data = bus_byte;
    if (core_wr && core_wr_file == cps_pkg::FILE_PC_LOW)
    begin
      pc_low_wr = 1'b1;
      pc_low_data = core_req.fr_wdata;
    end
    else if (bus_wr && bus_wr_hit && bus_wr_idx == cps_pkg::IDX_PC_LOW)
    begin
      pc_low_wr = 1'b1;
    end
  end

  // ==========================================================
  // Pointer, bank and latch registers; core writes win
  always_comb
  begin
    next_latch = latch;
    next_status = status;
    next_pointer = pointer;
    if (bus_wr && bus_wr_hit)
    begin
      case (bus_wr_idx)
        cps_pkg::IDX_LATCH: next_latch = bus_byte & cps_pkg::LATCH_MASK;
        cps_pkg::IDX_STATUS: next_status = bus_byte;
        cps_pkg::IDX_POINTER: next_pointer = bus_byte;
        default: next_latch = latch;
      endcase
    end
    if (core_wr)
    begin
      case (core_wr_file)
        cps_pkg::FILE_LATCH:
          next_latch = core_req.fr_wdata & cps_pkg::LATCH_MASK;
        cps_pkg::FILE_STATUS: next_status = core_req.fr_wdata;
        cps_pkg::FILE_POINTER: next_pointer = core_req.fr_wdata;
        default: next_latch = next_latch;
      endcase
    end
  end

  // ==========================================================
  // Interrupt flags and power control
  always_comb
  begin
    next_low_voltage_flag = low_voltage_flag;
    next_bus_collision_flag = bus_collision_flag;
    next_osc_speed_select = osc_speed_select;
    next_power_on_status = power_on_status;
    next_brownout_status = brownout_status;
    if (bus_wr && bus_wr_hit && bus_wr_idx == cps_pkg::IDX_FLAGS_TWO)
    begin
      next_low_voltage_flag = bus_byte[cps_pkg::LOW_VOLT_BIT];
      next_bus_collision_flag = bus_byte[cps_pkg::BUS_COLL_BIT];
    end
    if (bus_wr && bus_wr_hit && bus_wr_idx == cps_pkg::IDX_POWER)
    begin
      next_osc_speed_select = bus_byte[cps_pkg::OSC_SPEED_BIT];
      next_power_on_status = bus_byte[cps_pkg::POWER_ON_BIT]; // [RULE8]
      next_brownout_status = bus_byte[cps_pkg::BROWNOUT_BIT]; // [RULE9]
    end
    // Events set regardless of enables; set beats clear
    if (low_voltage_event)
    begin
      next_low_voltage_flag = 1'b1; // [RULE1] [RULE3]
    end
    if (bus_collision_event)
    begin
      next_bus_collision_flag = 1'b1; // [RULE1] [RULE4]
    end
  end

  // Oscillator slow select for the analog clock source
  always_comb
  begin
    case (osc_mode)
      cps_pkg::CPS_OSC_INTERNAL_RC: next_osc_slow = !osc_speed_select; // [RULE6]
      cps_pkg::CPS_OSC_RESISTOR: next_osc_slow = !osc_speed_select; // [RULE7]
      default: next_osc_slow = 1'b0; // [RULE7]
    endcase
  end

  // ==========================================================
  // Program counter and circular return stack
  always_comb
  begin
    next_pc = pc;
    next_sp = sp;
    push_en = 1'b0;
    push_data = pc;
    if (core_req.irq_branch)
    begin
      push_en = 1'b1; // [RULE15]
      push_data = pc;
      next_pc = IRQ_VECTOR;
    end
    else if (core_req.ret)
    begin
      next_sp = sp - 3'd1; // [RULE15] [RULE17]
      next_pc = stack_mem[next_sp]; // [RULE16]
    end
    else if (core_req.call || core_req.jump)
    begin
      if (core_req.call)
      begin
        push_en = 1'b1; // [RULE15]
        push_data = pc + 13'd1;
      end
      next_pc = {latch[cps_pkg::PAGE_HI_BIT:cps_pkg::PAGE_LO_BIT],
                 core_req.target}; // [RULE12] [RULE13]
    end
    else if (pc_low_wr)
    begin
      next_pc = {latch[4:0], pc_low_data}; // [RULE11] [RULE22]
    end
    else if (core_req.step)
    begin
      next_pc = pc + 13'd1;
    end
    if (push_en)
    begin
      next_sp = sp + 3'd1; // [RULE14] [RULE17]
    end
  end

  // ==========================================================
  // Indirect and direct file access resolution
  always_comb
  begin
    next_crsp.pc = next_pc;
    next_crsp.fa_valid = core_req.fr_valid;
    next_crsp.fa_we = core_req.fr_we;
    next_crsp.fa_null = 1'b0;
    next_crsp.fa_addr = core_req.fr_addr;
    next_crsp.fa_wdata = core_req.fr_wdata;
    if (core_req.fr_addr[6:0] == cps_pkg::FILE_INDIRECT)
    begin
      next_crsp.fa_addr = {status[cps_pkg::BANK_BIT], pointer}; // [RULE18] [RULE21]
      if (pointer == cps_pkg::BYTE_RST)
      begin
        next_crsp.fa_null = core_req.fr_valid; // [RULE19]
        next_crsp.fa_we = 1'b0; // [RULE20]
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rsp <= '0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      pc <= cps_pkg::PC_RST;
      latch <= cps_pkg::BYTE_RST;
      status <= cps_pkg::BYTE_RST;
      pointer <= cps_pkg::BYTE_RST;
      sp <= '0;
      crsp <= '0;
      low_voltage_flag <= cps_pkg::FLAGS_TWO_RST[cps_pkg::LOW_VOLT_BIT];
      bus_collision_flag <= cps_pkg::FLAGS_TWO_RST[cps_pkg::BUS_COLL_BIT];
      osc_speed_select <= cps_pkg::OSC_SPEED_RST; // [RULE6]
      osc_slow <= 1'b0;
      // Reset-cause bits: power-on cause clears both, brown-out cause clears the brown-out bit only
      if (power_on_cause)
      begin
        power_on_status <= 1'b0; // [RULE8]
        brownout_status <= 1'b0; // [RULE10]
      end
      if (brownout_cause)
      begin
        brownout_status <= 1'b0; // [RULE9]
      end
    end
    else if (ce)
    begin
      rsp <= next_rsp;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      pc <= next_pc;
      latch <= next_latch; // [RULE16]
      status <= next_status;
      pointer <= next_pointer;
      sp <= next_sp;
      crsp <= next_crsp;
      low_voltage_flag <= next_low_voltage_flag;
      bus_collision_flag <= next_bus_collision_flag;
      osc_speed_select <= next_osc_speed_select;
      power_on_status <= next_power_on_status;
      brownout_status <= next_brownout_status;
      osc_slow <= next_osc_slow;
    end
  end

  // Stack storage, no reset needed
  always_ff @(posedge core_clk)
  begin
    if (rst_n && ce && push_en)
    begin
      stack_mem[sp] <= push_data; // [RULE17]
    end
  end

  // Outputs straight from flops
  assign axi_rsp = rsp;
  assign core_rsp = crsp;
  assign osc_slow_select = osc_slow;

endmodule : cps_core_pc_stack_status

// ---- bench/cps_monitor.sv ----
// Assertion checker for the program-counter and status block
`timescale 1ns/1ps
module cps_monitor #(
  parameter logic [12:0] IRQ_VECTOR = 13'h0004
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire cps_pkg::cps_axi_req_t axi_req,
  input wire cps_pkg::cps_axi_rsp_t axi_rsp,
  input wire cps_pkg::cps_core_req_t core_req,
  input wire cps_pkg::cps_core_rsp_t core_rsp,
  input wire logic low_voltage_event,
  input wire logic bus_collision_event,
  input wire logic power_on_cause,
  input wire logic brownout_cause,
  input wire cps_pkg::cps_osc_mode_t osc_mode,
  input wire logic osc_slow_select
);
  // ==========================================================
  // Index of the read in flight
  logic [7:0] rd_idx;
  logic [7:0] next_rd_idx;

  // Capture index when the read address is taken
  always_comb
  begin
    next_rd_idx = rd_idx;
    if (ce && axi_req.arvalid && axi_rsp.arready)
      next_rd_idx = axi_req.araddr[9:2];
  end

  // Register the captured index
  always_ff @(posedge core_clk)
  begin
    rd_idx <= next_rd_idx;
  end

  // ==========================================================
  // Properties
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_call;
    ce && core_req.call && !core_req.irq_branch && !core_req.ret;
  endsequence

  sequence s_ret;
    ce && core_req.ret && !core_req.irq_branch;
  endsequence

  AST_CALL_RET: assert property (
    s_call ##1 s_ret |=> core_rsp.pc == $past(core_rsp.pc, 2) + 13'h0001)
    else $error("return did not resume after the call");
  AST_IRQ_BRANCH: assert property (
    ce && core_req.irq_branch |=> core_rsp.pc == IRQ_VECTOR)
    else $error("interrupt branch missed the vector");
  AST_BRANCH_LOW: assert property (
    ce && (core_req.jump || core_req.call) && !core_req.irq_branch
    && !core_req.ret |=> core_rsp.pc[10:0] == $past(core_req.target))
    else $error("branch target not loaded");
  AST_DIRECT: assert property (
    ce && core_req.fr_valid && core_req.fr_addr[6:0] != 7'h00
    |=> core_rsp.fa_valid && core_rsp.fa_addr == $past(core_req.fr_addr))
    else $error("direct access misrouted");
  AST_NULL_WR: assert property (
    ce && core_req.fr_valid && core_req.fr_we
    && core_req.fr_addr[6:0] == 7'h00 |=> core_rsp.fa_we == !core_rsp.fa_null)
    else $error("self-indirect write stored");
  AST_NULL_PTR: assert property (
    ce && core_req.fr_valid && core_req.fr_addr[6:0] == 7'h00 |=>
    core_rsp.fa_null == (core_rsp.fa_addr[7:0] == 8'h00))
    else $error("null access flag disagrees with pointer");
  AST_FLAG_GAPS: assert property (
    axi_rsp.rvalid && rd_idx == cps_pkg::IDX_FLAGS_TWO |->
    axi_rsp.rdata[31:8] == 24'h00_0000 && axi_rsp.rdata[6:4] == 3'h0
    && axi_rsp.rdata[2:0] == 3'h0)
    else $error("flag register gap bits not zero");
  AST_POWER_GAPS: assert property (
    axi_rsp.rvalid && rd_idx == cps_pkg::IDX_POWER |->
    axi_rsp.rdata[31:4] == 28'h000_0000 && !axi_rsp.rdata[2])
    else $error("power register gap bits not zero");
  AST_SPEED_RST: assert property (
    $rose(rst_n) |=> !osc_slow_select)
    else $error("slow clock chosen after reset");
  AST_OTHER_MODE: assert property (
    (osc_mode == cps_pkg::CPS_OSC_OTHER && ce) [*2] |-> !osc_slow_select)
    else $error("speed bit acted in another mode");
endmodule : cps_monitor

bind cps_core_pc_stack_status cps_monitor #(.IRQ_VECTOR(IRQ_VECTOR))
  cps_monitor_i (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .ce(ce),
  .axi_req(axi_req),
  .axi_rsp(axi_rsp),
  .core_req(core_req),
  .core_rsp(core_rsp),
  .low_voltage_event(low_voltage_event),
  .bus_collision_event(bus_collision_event),
  .power_on_cause(power_on_cause),
  .brownout_cause(brownout_cause),
  .osc_mode(osc_mode),
  .osc_slow_select(osc_slow_select)
);

// ---- bench/tb_core_pc_stack_status.sv ----
// Self-checking bench for the program-counter and status block
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_core_pc_stack_status;
  localparam logic [12:0] IRQ_V = 13'h0004;
  localparam logic [4:0] JMP = 5'h08, CAL = 5'h04, IRQ = 5'h02, RET = 5'h01;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  cps_pkg::cps_axi_req_t axi_req = '0;
  cps_pkg::cps_axi_rsp_t axi_rsp;
  cps_pkg::cps_core_req_t core_req = '0;
  cps_pkg::cps_core_rsp_t core_rsp;
  logic low_voltage_event = 1'b0;
  logic bus_collision_event = 1'b0;
  logic power_on_cause = 1'b1;
  logic brownout_cause = 1'b0;
  cps_pkg::cps_osc_mode_t osc_mode = cps_pkg::CPS_OSC_INTERNAL_RC;
  logic osc_slow_select;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  cps_core_pc_stack_status #(.IRQ_VECTOR(IRQ_V)) cps_core_pc_stack_status_i (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .core_req(core_req),
    .core_rsp(core_rsp),
    .low_voltage_event(low_voltage_event),
    .bus_collision_event(bus_collision_event),
    .power_on_cause(power_on_cause),
    .brownout_cause(brownout_cause),
    .osc_mode(osc_mode),
    .osc_slow_select(osc_slow_select)
  );

  // ==========================================================
  // Clock and hang guard
  always #25 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  // ==========================================================
  // Bus, core and reset helpers
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
    input logic [1:0] er = cps_pkg::RESP_OKAY);
    @(posedge core_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= {2'b00, idx, 2'b00};
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= {24'h00_0000, d};
    axi_req.wstrb <= 4'h1;
    axi_req.bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    axi_req.bready <= 1'b0;
    `CHK("bresp", er, axi_rsp.bresp)
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [15:0] ed,
    input logic [1:0] er = cps_pkg::RESP_OKAY);
    @(posedge core_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= {2'b00, idx, 2'b00};
    axi_req.rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    axi_req.rready <= 1'b0;
    `CHK("rresp", er, axi_rsp.rresp)
    `CHK("rdata", {16'h0000, ed}, axi_rsp.rdata)
  endtask : rd

  task automatic put(input cps_pkg::cps_core_req_t r);
    @(posedge core_clk);
    core_req <= r;
  endtask : put

  task automatic op(input cps_pkg::cps_core_req_t r);
    put(r);
    put('0);
    @(posedge core_clk);
  endtask : op

  function automatic cps_pkg::cps_core_req_t br(input logic [4:0] k,
    input logic [10:0] t);
    br = '0;
    {br.step, br.jump, br.call, br.irq_branch, br.ret} = k;
    br.target = t;
  endfunction : br

  task automatic ind(input logic we, input logic [8:0] a,
    input logic [11:0] e);
    cps_pkg::cps_core_req_t r;
    r = '0;
    r.fr_valid = 1'b1;
    r.fr_we = we;
    r.fr_addr = a;
    r.fr_wdata = 8'h5a;
    op(r);
    `CHK("access", e, {core_rsp.fa_valid, core_rsp.fa_we,
      core_rsp.fa_null, core_rsp.fa_addr})
    `CHK("wdata", 8'h5a, core_rsp.fa_wdata)
  endtask : ind

  task automatic rst(input logic po, input logic bo);
    @(posedge core_clk);
    rst_n <= 1'b0;
    power_on_cause <= po;
    brownout_cause <= bo;
    core_req <= '0;
    axi_req <= '0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask : rst

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(cps_pkg::IDX_FLAGS_TWO, 16'h0000);
    rd(cps_pkg::IDX_POWER, 16'h0008);
    `CHK("slow", 1'b0, osc_slow_select)
    rd(cps_pkg::IDX_PC_VIEW, 16'h0000);
    rd(8'h05, 16'h0000, cps_pkg::RESP_SLVERR);
    wr(cps_pkg::IDX_PC_VIEW, 8'hff, cps_pkg::RESP_SLVERR);
    $display("reset test done");
  endtask : t_reset

  task automatic t_flags();
    @(posedge core_clk);
    low_voltage_event <= 1'b1;
    @(posedge core_clk);
    low_voltage_event <= 1'b0;
    rd(cps_pkg::IDX_FLAGS_TWO, 16'h0080);
    bus_collision_event <= 1'b1;
    @(posedge core_clk);
    bus_collision_event <= 1'b0;
    rd(cps_pkg::IDX_FLAGS_TWO, 16'h0088);
    wr(cps_pkg::IDX_FLAGS_TWO, 8'h08);
    rd(cps_pkg::IDX_FLAGS_TWO, 16'h0008);
    low_voltage_event <= 1'b1;
    wr(cps_pkg::IDX_FLAGS_TWO, 8'h00);
    low_voltage_event <= 1'b0;
    rd(cps_pkg::IDX_FLAGS_TWO, 16'h0080);
    wr(cps_pkg::IDX_FLAGS_TWO, 8'h77);
    rd(cps_pkg::IDX_FLAGS_TWO, 16'h0000);
    $display("flag test done");
  endtask : t_flags

  task automatic t_power();
    wr(cps_pkg::IDX_POWER, 8'hff);
    rd(cps_pkg::IDX_POWER, 16'h000b);
    for (int m = 0; m < 3; m++)
      for (int s = 0; s < 2; s++)
      begin
        osc_mode <= cps_pkg::cps_osc_mode_t'(m);
        wr(cps_pkg::IDX_POWER, {4'h0, s[0], 3'h3});
        repeat (2) @(posedge core_clk);
        `CHK("slow", (m < 2 && s == 0), osc_slow_select)
      end
    rst(1'b0, 1'b1);
    rd(cps_pkg::IDX_POWER, 16'h000a);
    wr(cps_pkg::IDX_POWER, 8'h03);
    rst(1'b0, 1'b0);
    rd(cps_pkg::IDX_POWER, 16'h000b);
    rst(1'b1, 1'b0);
    rd(cps_pkg::IDX_POWER, 16'h0008);
    $display("power test done");
  endtask : t_power

  task automatic t_pc();
    wr(cps_pkg::IDX_LATCH, 8'hff);
    rd(cps_pkg::IDX_LATCH, 16'h001f);
    ind(1'b1, 9'h002, {3'b110, 9'h002});
    `CHK("pc", 13'h1f5a, core_rsp.pc)
    rd(cps_pkg::IDX_PC_VIEW, 16'h1f5a);
    op(br(JMP, 11'h2aa));
    `CHK("pc", 13'h1aaa, core_rsp.pc)
    wr(cps_pkg::IDX_LATCH, 8'h0e);
    op(br(CAL, 11'h155));
    `CHK("pc", 13'h0955, core_rsp.pc)
    op(br(IRQ, 11'h000));
    `CHK("pc", IRQ_V, core_rsp.pc)
    op(br(RET, 11'h000));
    `CHK("pc", 13'h0955, core_rsp.pc)
    op(br(RET, 11'h000));
    `CHK("pc", 13'h1aab, core_rsp.pc)
    rd(cps_pkg::IDX_LATCH, 16'h000e);
    $display("counter test done");
  endtask : t_pc

  task automatic t_stack();
    wr(cps_pkg::IDX_LATCH, 8'h07);
    for (int k = 0; k < 10; k++)
      put(br(CAL, 11'h100 + k[10:0]));
    put('0);
    for (int k = 9; k > 0; k--)
    begin
      op(br(RET, 11'h000));
      `CHK("pop", 13'(13'h0100 + (k > 1 ? k : 9)), core_rsp.pc)
    end
    put(br(CAL, 11'h0aa));
    put(br(RET, 11'h000));
    put('0);
    @(posedge core_clk);
    `CHK("pc", 13'h010a, core_rsp.pc)
    ce <= 1'b0;
    op(br(JMP, 11'h3ff));
    `CHK("frozen", 13'h010a, core_rsp.pc)
    ce <= 1'b1;
    op(br(5'h10, 11'h000));
    `CHK("step", 13'h010b, core_rsp.pc)
    rd(cps_pkg::IDX_LATCH, 16'h0007);
    $display("stack test done");
  endtask : t_stack

  task automatic t_ind();
    wr(cps_pkg::IDX_POINTER, 8'h25);
    wr(cps_pkg::IDX_STATUS, 8'h80);
    ind(1'b1, 9'h000, {3'b110, 9'h125});
    ind(1'b0, 9'h020, {3'b100, 9'h020});
    wr(cps_pkg::IDX_STATUS, 8'h00);
    ind(1'b0, 9'h000, {3'b100, 9'h025});
    wr(cps_pkg::IDX_POINTER, 8'h00);
    ind(1'b1, 9'h000, {3'b101, 9'h000});
    ind(1'b0, 9'h000, {3'b101, 9'h000});
    $display("indirect test done");
  endtask : t_ind

  // ==========================================================
  // Main sequence
  initial
  begin
    rst(1'b1, 1'b0);
    t_reset();
    t_flags();
    t_power();
    t_pc();
    t_stack();
    t_ind();
    end_of_test();
  end
endmodule : tb_core_pc_stack_status
